// ==== core/brw_pkg.sv ====
// constants for the bridge window and interrupt configuration registers
package brw_pkg;

    // -----------------------------------------------------------------
    // configuration byte offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] BRW_OFS_PF_BASE_HI  = 8'h28;
    localparam logic [7:0] BRW_OFS_PF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] BRW_OFS_IO_BASE_HI  = 8'h30;
    localparam logic [7:0] BRW_OFS_IO_LIMIT_HI = 8'h32;
    localparam logic [7:0] BRW_OFS_CAP_PTR     = 8'h34;
    localparam logic [7:0] BRW_OFS_IRQ_LINE    = 8'h3c;
    localparam logic [7:0] BRW_OFS_IRQ_PIN     = 8'h3d;

    // dword number of a byte offset, and byte lane inside its dword
    localparam int BRW_DW_HI = 7;
    localparam int BRW_DW_LO = 2;
    localparam int BRW_LANE_W = 8;
    localparam int BRW_LANES  = 4;

    // -----------------------------------------------------------------
    // reset and hardwired values
    // -----------------------------------------------------------------
    localparam logic [31:0] BRW_RST_PF_HI    = 32'h0000_0000;
    localparam logic [15:0] BRW_RST_IO_HI    = 16'h0000;
    localparam logic [7:0]  BRW_CAP_PTR_VAL  = 8'h50;
    localparam logic [7:0]  BRW_RST_IRQ_LINE = 8'hff;
    localparam logic [7:0]  BRW_IRQ_PIN_INTA = 8'h01;

    // -----------------------------------------------------------------
    // window field layout
    // -----------------------------------------------------------------
    localparam int          BRW_PF_LOW_W    = 12;
    localparam int          BRW_PF_FILL_W   = 20;
    localparam logic [19:0] BRW_PF_BASE_FILL  = 20'h0_0000;
    localparam logic [19:0] BRW_PF_LIMIT_FILL = 20'hf_ffff;
    localparam int          BRW_IO_LOW_W    = 4;
    localparam int          BRW_IO_FILL_W   = 12;
    localparam logic [11:0] BRW_IO_BASE_FILL  = 12'h000;
    localparam logic [11:0] BRW_IO_LIMIT_FILL = 12'hfff;
    localparam int          BRW_PF_ADDR_W   = 64;
    localparam int          BRW_IO_ADDR_W   = 32;

endpackage

// ==== core/brw_window_cmp.sv ====
// inclusive address window comparator with a registered hit
module brw_window_cmp
    import brw_pkg::*;
#(
    parameter int AW = 64
)
(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          req_valid,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [AW-1:0] win_base,
    input  wire logic [AW-1:0] win_limit,
    output logic               hit_q
);

    logic hit_d;

    // -----------------------------------------------------------------
    // both ends count as inside the window
    // -----------------------------------------------------------------
    always_comb
    begin
        hit_d = req_valid && (req_addr >= win_base) && (req_addr <= win_limit);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            hit_q <= 1'b0;
        end
        else
        begin
            hit_q <= hit_d;
        end
    end

endmodule

// ==== core/brw_cfg_regs.sv ====
// window upper halves, capability pointer and interrupt config registers
// Functional notes
// [R1] prefetch base upper 32 bits: read/write, resets to zero
// [R2] prefetch limit upper 32 bits: read/write, resets to zero
// [R3] I/O base upper 16 bits: read/write, resets to zero
// [R4] I/O limit upper 16 bits: read/write, resets to zero
// [R5] prefetch base takes bits 31:20 from low field, bits 19:0 zero
// [R6] limit takes bits 31:20 from limit field, bits 19:0 all ones
// [R7] forward downstream only when address lies inclusively in window
// [R8] capability pointer is read-only and always returns 50h
// [R9] interrupt line is 8-bit read/write, resets to FFh
// [R10] interrupt line stores writes, reads back, affects nothing inside
// [R11] interrupt pin is read-only, returns 01h meaning INTA
// [R12] port legacy interrupts go upstream only through upstream bridge
// [R13] host programs interrupt line after enumeration; hardware never does
module brw_cfg_regs
    import brw_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_n,
    // configuration access, one dword per request
    input  wire logic                     cfg_req,
    input  wire logic                     cfg_we,
    input  wire logic [5:0]               cfg_dword,
    input  wire logic [3:0]               cfg_byte_en,
    input  wire logic [31:0]              cfg_wdata,
    output logic                          cfg_ack,
    output logic [31:0]                   cfg_rdata,
    // lower window fields held by neighbouring registers
    input  wire logic [BRW_PF_LOW_W-1:0]  pf_base_low_field,
    input  wire logic [BRW_PF_LOW_W-1:0]  pf_limit_low_field,
    input  wire logic [BRW_IO_LOW_W-1:0]  io_base_low_field,
    input  wire logic [BRW_IO_LOW_W-1:0]  io_limit_low_field,
    // downstream forwarding decision
    input  wire logic                     req_valid,
    input  wire logic                     req_is_io,
    input  wire logic [63:0]              req_addr,
    output logic                          fwd_pf_hit,
    output logic                          fwd_io_hit,
    output logic                          fwd_downstream,
    // legacy interrupt from this port
    input  wire logic                     port_intx,
    output logic                          upstream_inta,
    // window values for the forwarding logic
    output logic [63:0]                   pf_win_base,
    output logic [63:0]                   pf_win_limit,
    output logic [31:0]                   io_win_base,
    output logic [31:0]                   io_win_limit
);

    localparam logic [5:0] DW_PF_BASE  =
        BRW_OFS_PF_BASE_HI[BRW_DW_HI:BRW_DW_LO];
    localparam logic [5:0] DW_PF_LIMIT =
        BRW_OFS_PF_LIMIT_HI[BRW_DW_HI:BRW_DW_LO];
    localparam logic [5:0] DW_IO       =
        BRW_OFS_IO_BASE_HI[BRW_DW_HI:BRW_DW_LO];
    localparam logic [5:0] DW_CAP      = BRW_OFS_CAP_PTR[BRW_DW_HI:BRW_DW_LO];
    localparam logic [5:0] DW_IRQ      =
        BRW_OFS_IRQ_LINE[BRW_DW_HI:BRW_DW_LO];
    localparam int LANE_IO_LIMIT = int'(BRW_OFS_IO_LIMIT_HI[1:0]);
    localparam int LANE_IRQ_PIN  = int'(BRW_OFS_IRQ_PIN[1:0]);

    logic [31:0] prefetch_window_base_field_q;
    logic [31:0] prefetch_window_limit_field_q;
    logic [15:0] io_window_base_field_q;
    logic [15:0] io_window_limit_field_q;
    logic [7:0]  irq_line_q;
    logic [31:0] rdata_d;
    logic [31:0] io_dword;
    logic [31:0] io_dword_new;
    logic        wr_pf_base;
    logic        wr_pf_limit;
    logic        wr_io;
    logic        wr_irq;
    logic        io_hit_raw;
    logic        intx_q;

    // -----------------------------------------------------------------
    // write decode
    // -----------------------------------------------------------------
    assign wr_pf_base  = cfg_req && cfg_we && (cfg_dword == DW_PF_BASE);
    assign wr_pf_limit = cfg_req && cfg_we && (cfg_dword == DW_PF_LIMIT);
    assign wr_io       = cfg_req && cfg_we && (cfg_dword == DW_IO);
    assign wr_irq      = cfg_req && cfg_we && (cfg_dword == DW_IRQ);

    // merge one dword with the enabled byte lanes of the write data
    function automatic logic [31:0] brw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < BRW_LANES; i++)
        begin
            if (be[i])
            begin
                res[i*BRW_LANE_W +: BRW_LANE_W] =
                    new_v[i*BRW_LANE_W +: BRW_LANE_W];
            end
        end
        return res;
    endfunction

    assign io_dword     = {io_window_limit_field_q, io_window_base_field_q};
    assign io_dword_new = brw_merge(io_dword, cfg_wdata, cfg_byte_en);

    // -----------------------------------------------------------------
    // prefetch window upper halves
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prefetch_window_base_field_q <= BRW_RST_PF_HI;    // [R1]
        end
        else if (wr_pf_base)
        begin
            prefetch_window_base_field_q <= brw_merge(
                prefetch_window_base_field_q, cfg_wdata, cfg_byte_en); // [R1]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prefetch_window_limit_field_q <= BRW_RST_PF_HI;   // [R2]
        end
        else if (wr_pf_limit)
        begin
            prefetch_window_limit_field_q <= brw_merge(
                prefetch_window_limit_field_q, cfg_wdata, cfg_byte_en); // [R2]
        end
    end

    // -----------------------------------------------------------------
    // I/O window upper halves share one dword
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            io_window_base_field_q  <= BRW_RST_IO_HI;          // [R3]
            io_window_limit_field_q <= BRW_RST_IO_HI;          // [R4]
        end
        else if (wr_io)
        begin
            io_window_base_field_q  <= io_dword_new[15:0];     // [R3]
            io_window_limit_field_q <= io_dword_new[31:16];    // [R4]
        end
    end

    // -----------------------------------------------------------------
    // interrupt line: scratch pad, read back only
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            irq_line_q <= BRW_RST_IRQ_LINE;                    // [R9]
        end
        else if (wr_irq && cfg_byte_en[0])
        begin
            irq_line_q <= cfg_wdata[BRW_LANE_W-1:0];           // [R10]
        end
    end

    // -----------------------------------------------------------------
    // read mux; unmapped dwords and the bridge control half read zero
    // -----------------------------------------------------------------
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (cfg_dword == DW_PF_BASE)
        begin
            rdata_d = prefetch_window_base_field_q;
        end
        else if (cfg_dword == DW_PF_LIMIT)
        begin
            rdata_d = prefetch_window_limit_field_q;
        end
        else if (cfg_dword == DW_IO)
        begin
            rdata_d[LANE_IO_LIMIT*BRW_LANE_W +: 16] = io_window_limit_field_q;
            rdata_d[15:0] = io_window_base_field_q;
        end
        else if (cfg_dword == DW_CAP)
        begin
            rdata_d[BRW_LANE_W-1:0] = BRW_CAP_PTR_VAL;          // [R8]
        end
        else if (cfg_dword == DW_IRQ)
        begin
            rdata_d[BRW_LANE_W-1:0] = irq_line_q;
            rdata_d[LANE_IRQ_PIN*BRW_LANE_W +: BRW_LANE_W] =
                BRW_IRQ_PIN_INTA;                              // [R11]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cfg_ack   <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end
        else
        begin
            cfg_ack   <= cfg_req;
            cfg_rdata <= (cfg_req && !cfg_we) ? rdata_d : 32'h0000_0000;
        end
    end

    // -----------------------------------------------------------------
    // assembled windows
    // -----------------------------------------------------------------
    assign pf_win_base  = {prefetch_window_base_field_q, pf_base_low_field,
                           BRW_PF_BASE_FILL};                  // [R5]
    assign pf_win_limit = {prefetch_window_limit_field_q, pf_limit_low_field,
                           BRW_PF_LIMIT_FILL};                 // [R6]
    assign io_win_base  = {io_window_base_field_q, io_base_low_field,
                           BRW_IO_BASE_FILL};
    assign io_win_limit = {io_window_limit_field_q, io_limit_low_field,
                           BRW_IO_LIMIT_FILL};

    brw_window_cmp #(.AW(BRW_PF_ADDR_W)) u_pf_cmp
    (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .req_valid (req_valid && !req_is_io),
        .req_addr  (req_addr),
        .win_base  (pf_win_base),
        .win_limit (pf_win_limit),
        .hit_q     (fwd_pf_hit)
    );

    // I/O space is 32 bits; any upper address bit set misses
    brw_window_cmp #(.AW(BRW_IO_ADDR_W)) u_io_cmp
    (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .req_valid (req_valid && req_is_io && ~|req_addr[63:32]),
        .req_addr  (req_addr[31:0]),
        .win_base  (io_win_base),
        .win_limit (io_win_limit),
        .hit_q     (io_hit_raw)
    );

    assign fwd_io_hit     = io_hit_raw;
    assign fwd_downstream = fwd_pf_hit || io_hit_raw;          // [R7]

    // -----------------------------------------------------------------
    // legacy interrupt: always signalled upstream as INTA
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            intx_q <= 1'b0;
        end
        else
        begin
            intx_q <= port_intx;                               // [R12]
        end
    end

    assign upstream_inta = intx_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    AST_PF_BASE_WR: assert property (@(posedge ref_clk) // [R1]
        disable iff (!rst_n) wr_pf_base && (cfg_byte_en == 4'hf) |=>
            prefetch_window_base_field_q == $past(cfg_wdata))
        else $error("prefetch base upper write lost");

    AST_PF_LIMIT_RST: assert property (@(posedge ref_clk) // [R2]
        !rst_n |=> (prefetch_window_limit_field_q == BRW_RST_PF_HI)
            && (prefetch_window_base_field_q == BRW_RST_PF_HI))
        else $error("prefetch upper halves not zero after reset");

    AST_IO_WR: assert property (@(posedge ref_clk) // [R3]
        disable iff (!rst_n) wr_io && (cfg_byte_en == 4'h3) |=>
            (io_window_base_field_q == $past(cfg_wdata[15:0]))
            && $stable(io_window_limit_field_q))
        else $error("io base upper write wrong");

    AST_IO_RD: assert property (@(posedge ref_clk) // [R4]
        disable iff (!rst_n) cfg_req && !cfg_we && (cfg_dword == DW_IO) |=>
            cfg_ack && (cfg_rdata[31:16] == io_window_limit_field_q))
        else $error("io limit upper read wrong");

    AST_PF_BASE_EDGE: assert property (@(posedge ref_clk) // [R5]
        disable iff (!rst_n) req_valid && !req_is_io
            && (req_addr == pf_win_base)
            && (pf_win_base <= pf_win_limit) |=> fwd_pf_hit && fwd_downstream)
        else $error("window base address not forwarded");

    AST_PF_LIMIT_EDGE: assert property (@(posedge ref_clk) // [R6]
        disable iff (!rst_n) req_valid && !req_is_io
            && (req_addr[19:0] == BRW_PF_LIMIT_FILL)
            && (req_addr[63:20] == pf_win_limit[63:20])
            && (pf_win_base <= pf_win_limit) |=> fwd_pf_hit)
        else $error("window limit address not forwarded");

    AST_OUTSIDE_MISS: assert property (@(posedge ref_clk) // [R7]
        disable iff (!rst_n) req_valid
            && ((req_is_io && (req_addr[31:0] > io_win_limit))
            || (!req_is_io && (req_addr < pf_win_base))) |=> !fwd_downstream)
        else $error("address outside window forwarded");

    AST_CAP_RO: assert property (@(posedge ref_clk) // [R8]
        disable iff (!rst_n) cfg_req && !cfg_we && (cfg_dword == DW_CAP) |=>
            cfg_ack && (cfg_rdata == {24'h00_0000, BRW_CAP_PTR_VAL}))
        else $error("capability pointer read wrong");

    AST_IRQ_LINE_RST: assert property (@(posedge ref_clk) // [R9]
        !rst_n |=> irq_line_q == BRW_RST_IRQ_LINE)
        else $error("interrupt line not all ones after reset");

    AST_IRQ_LINE_RB: assert property (@(posedge ref_clk) // [R10]
        disable iff (!rst_n) wr_irq && cfg_byte_en[0]
            ##1 cfg_req && !cfg_we && (cfg_dword == DW_IRQ)
            |=> cfg_rdata[7:0] == $past(cfg_wdata[7:0], 2))
        else $error("interrupt line read back wrong");

    AST_IRQ_PIN: assert property (@(posedge ref_clk) // [R11]
        disable iff (!rst_n) cfg_req && !cfg_we && (cfg_dword == DW_IRQ) |=>
            cfg_rdata[15:8] == BRW_IRQ_PIN_INTA)
        else $error("interrupt pin not INTA");

    AST_INTA_FOLLOW: assert property (@(posedge ref_clk) // [R12]
        disable iff (!rst_n) $rose(port_intx) |=> upstream_inta
            ##1 (upstream_inta == $past(port_intx)))
        else $error("legacy interrupt not passed upstream");

endmodule

// ==== dv/brw_host_model.sv ====
// host configuration software model driving the config access port
module brw_host_model
    import brw_pkg::*;
(
    input  wire logic        ref_clk,
    output logic             cfg_req,
    output logic             cfg_we,
    output logic [5:0]       cfg_dword,
    output logic [3:0]       cfg_byte_en,
    output logic [31:0]      cfg_wdata,
    input  wire logic        cfg_ack,
    input  wire logic [31:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cfg_req     = 1'b0;
        cfg_we      = 1'b0;
        cfg_dword   = 6'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata   = 32'h0000_0000;
    end

    // -----------------------------------------------------------------
    // one access: the request is a single-edge pulse, answer a cycle on
    // -----------------------------------------------------------------
    task automatic access(input logic we, input logic [5:0] dw,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic ack, output logic [31:0] rd);
        @(negedge ref_clk);
        cfg_req     = 1'b1;
        cfg_we      = we;
        cfg_dword   = dw;
        cfg_byte_en = be;
        cfg_wdata   = wd;
        @(negedge ref_clk);
        ack         = cfg_ack;
        rd          = cfg_rdata;
        // released lines must not keep showing the last value
        cfg_req     = 1'b0;
        cfg_we      = ~we;
        cfg_dword   = ~dw;
        cfg_byte_en = ~be;
        cfg_wdata   = ~wd;
    endtask

    // the hardware never fills in the line, so software does it here
    task automatic program_irq_line(input logic [7:0] line,
                                    output logic ack);
        logic [31:0] rd;
        access(1'b1, 6'h0f, 4'h1, {24'h00_0000, line}, ack, rd);
    endtask

    // write a dword and read it back on the very next edge
    task automatic wr_then_rd(input logic [5:0] dw, input logic [31:0] wd,
                              output logic [31:0] rd);
        @(negedge ref_clk);
        cfg_req     = 1'b1;
        cfg_we      = 1'b1;
        cfg_dword   = dw;
        cfg_byte_en = 4'hf;
        cfg_wdata   = wd;
        @(negedge ref_clk);
        cfg_we      = 1'b0;
        @(negedge ref_clk);
        rd          = cfg_rdata;
        cfg_req     = 1'b0;
        cfg_dword   = ~dw;
        cfg_wdata   = ~wd;
    endtask

endmodule

// ==== dv/bridge_window_intr_cfg_tb.sv ====
// self-checking bench for the bridge window and interrupt config registers
module bridge_window_intr_cfg_tb
    import brw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cfg_req, cfg_we, cfg_ack;
    logic [5:0]  cfg_dword;
    logic [3:0]  cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic [11:0] pf_base_low_field = 12'h000;
    logic [11:0] pf_limit_low_field = 12'h000;
    logic [3:0]  io_base_low_field = 4'h0;
    logic [3:0]  io_limit_low_field = 4'h0;
    logic        req_valid = 1'b0;
    logic        req_is_io = 1'b0;
    logic [63:0] req_addr = 64'h0;
    logic        fwd_pf_hit, fwd_io_hit, fwd_downstream;
    logic        port_intx = 1'b0;
    logic        upstream_inta;
    logic [63:0] pf_win_base, pf_win_limit;
    logic [31:0] io_win_base, io_win_limit;
    int          errors = 0;
    int          n_checks = 0;

    brw_host_model host (.ref_clk(ref_clk), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    brw_cfg_regs uut (.ref_clk(ref_clk), .rst_n(rst_n), .cfg_req(cfg_req),
        .cfg_we(cfg_we), .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
        .pf_base_low_field(pf_base_low_field),
        .pf_limit_low_field(pf_limit_low_field),
        .io_base_low_field(io_base_low_field),
        .io_limit_low_field(io_limit_low_field), .req_valid(req_valid),
        .req_is_io(req_is_io), .req_addr(req_addr),
        .fwd_pf_hit(fwd_pf_hit), .fwd_io_hit(fwd_io_hit),
        .fwd_downstream(fwd_downstream), .port_intx(port_intx),
        .upstream_inta(upstream_inta), .pf_win_base(pf_win_base),
        .pf_win_limit(pf_win_limit), .io_win_base(io_win_base),
        .io_win_limit(io_win_limit));

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    // -----------------------------------------------------------------
    // shared helpers
    // -----------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ack and read data stand for exactly one cycle, then drop to zero
    task automatic acc(input logic we, input logic [5:0] dw,
                       input logic [3:0] be, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic ack;
        host.access(we, dw, be, wd, ack, rd);
        chk("cfg_ack", ack, 1'b1);
        @(negedge ref_clk);
        chk("cfg_ack low", cfg_ack, 1'b0);
        chk("cfg_rdata idle", cfg_rdata, 32'h0);
    endtask

    task automatic wr(input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd);
        logic [31:0] rd;
        acc(1'b1, dw, be, wd, rd);
    endtask

    task automatic rd_chk(input logic [5:0] dw, input logic [31:0] exp);
        logic [31:0] rd;
        acc(1'b0, dw, 4'h0, 32'h0, rd);
        chk($sformatf("dword %h", dw), rd, exp);
    endtask

    task automatic lookup(input logic is_io, input logic [63:0] addr,
                          input logic pf, input logic io);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_is_io = is_io;
        req_addr  = addr;
        @(negedge ref_clk);
        req_valid = 1'b0;
        req_addr  = ~addr;
        chk("fwd_pf_hit", fwd_pf_hit, pf);
        chk("fwd_io_hit", fwd_io_hit, io);
        chk("fwd_downstream", fwd_downstream, pf | io);
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset_values();
        rd_chk(6'h0a, 32'h0000_0000);
        rd_chk(6'h0b, 32'h0000_0000);
        rd_chk(6'h0c, 32'h0000_0000);
        rd_chk(6'h0d, 32'h0000_0050);
        rd_chk(6'h0f, 32'h0000_01ff);
        rd_chk(6'h0e, 32'h0000_0000);
        $display("test reset_values done");
    endtask

    task automatic t_read_write();
        logic ack;
        logic [31:0] rd;
        wr(6'h0a, 4'hf, 32'hffff_ffff);
        rd_chk(6'h0a, 32'hffff_ffff);
        wr(6'h0a, 4'h5, 32'h1234_5678);
        rd_chk(6'h0a, 32'hff34_ff78);
        wr(6'h0b, 4'hf, 32'ha5a5_5a5a);
        rd_chk(6'h0b, 32'ha5a5_5a5a);
        wr(6'h0c, 4'hf, 32'h1234_abcd);
        rd_chk(6'h0c, 32'h1234_abcd);
        wr(6'h0c, 4'hc, 32'hbeef_0000);
        rd_chk(6'h0c, 32'hbeef_abcd);
        wr(6'h0c, 4'h3, 32'h5555_4321);
        rd_chk(6'h0c, 32'hbeef_4321);
        wr(6'h0d, 4'hf, 32'hffff_ffff);
        rd_chk(6'h0d, 32'h0000_0050);
        wr(6'h0f, 4'hf, 32'hffff_0000);
        rd_chk(6'h0f, 32'h0000_0100);
        host.program_irq_line(8'h0b, ack);
        chk("irq line ack", ack, 1'b1);
        @(negedge ref_clk);
        rd_chk(6'h0f, 32'h0000_010b);
        host.wr_then_rd(6'h0f, 32'h0000_0042, rd);
        chk("irq line back to back", rd, 32'h0000_0142);
        wr(6'h0e, 4'hf, 32'hffff_ffff);
        rd_chk(6'h0e, 32'h0000_0000);
        $display("test read_write done");
    endtask

    task automatic t_windows();
        pf_base_low_field  = 12'h123;
        pf_limit_low_field = 12'h456;
        io_base_low_field  = 4'h3;
        io_limit_low_field = 4'h5;
        wr(6'h0a, 4'hf, 32'h0000_0001);
        wr(6'h0b, 4'hf, 32'h0000_0001);
        wr(6'h0c, 4'hf, 32'h0002_0002);
        chk("pf_win_base", pf_win_base, 64'h0000_0001_1230_0000);
        chk("pf_win_limit", pf_win_limit, 64'h0000_0001_456f_ffff);
        chk("io_win_base", io_win_base, 32'h0002_3000);
        chk("io_win_limit", io_win_limit, 32'h0002_5fff);
        lookup(1'b0, 64'h0000_0001_1230_0000, 1'b1, 1'b0);
        lookup(1'b0, 64'h0000_0001_122f_ffff, 1'b0, 1'b0);
        lookup(1'b0, 64'h0000_0001_456f_ffff, 1'b1, 1'b0);
        lookup(1'b0, 64'h0000_0001_4570_0000, 1'b0, 1'b0);
        lookup(1'b1, 64'h0000_0000_0002_3000, 1'b0, 1'b1);
        lookup(1'b1, 64'h0000_0000_0002_2fff, 1'b0, 1'b0);
        lookup(1'b1, 64'h0000_0000_0002_5fff, 1'b0, 1'b1);
        lookup(1'b1, 64'h0000_0000_0002_6000, 1'b0, 1'b0);
        lookup(1'b1, 64'h0000_0001_0002_3000, 1'b0, 1'b0);
        lookup(1'b0, 64'h0000_0000_0002_3000, 1'b0, 1'b0);
        // interrupt line is scratch-pad: a new value leaves hits alone
        wr(6'h0f, 4'h1, 32'h0000_0033);
        lookup(1'b0, 64'h0000_0001_3000_0000, 1'b1, 1'b0);
        wr(6'h0b, 4'hf, 32'h0000_0000);
        lookup(1'b0, 64'h0000_0001_1230_0000, 1'b0, 1'b0);
        $display("test windows done");
    endtask

    task automatic t_interrupt();
        @(negedge ref_clk);
        port_intx = 1'b1;
        #1;
        chk("upstream_inta early", upstream_inta, 1'b0);
        @(negedge ref_clk);
        chk("upstream_inta", upstream_inta, 1'b1);
        port_intx = 1'b0;
        @(negedge ref_clk);
        chk("upstream_inta off", upstream_inta, 1'b0);
        $display("test interrupt done");
    endtask

    // -----------------------------------------------------------------
    // run control
    // -----------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        t_reset_values();
        t_read_write();
        t_windows();
        t_interrupt();
        complete_run();
    end

    // whole run is about 130 cycles; this leaves ample margin
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        errors++;
        complete_run();
    end

endmodule
